//--- verilog/bbie_core.sv
// How it works
// - writes to program counter clear bit nine
// - port read-modify-write reads the pin levels
// - direction load of file six copies accumulator
// - direction bit one releases pin, zero drives
// - timer file write clears assigned prescaler
// - destination bit picks accumulator or file
// - register add sets carry, digit carry, zero
// - register AND updates zero flag only
// - literal AND into accumulator, updates zero
// - bit clear, flags untouched
// - bit set, flags untouched
// - skip next when tested bit is zero
// - skip next when tested bit is one
// - skipped instruction runs as no operation
// - byte op fields: opcode, destination, file
// - four clocks per cycle, changes take two
`timescale 1ns/1ps
module bbie_core
	import bbie_pkg::*;
#(
	parameter int PORT_W = DATA_W
)(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic [BUS_W-1:0]  bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic [BUS_W-1:0]       bus_rdata,
	input  wire logic [PORT_W-1:0] gp_pin_in,
	output logic [PORT_W-1:0]      gp_pin_out,
	output logic [PORT_W-1:0]      gp_pin_oe
);

	// sequencer state
	bbie_state_t           state_ff;   // idle, executing, or second cycle
	bbie_state_t           nxt_state;
	logic [1:0]            phase_ff;   // oscillator period within cycle
	logic [1:0]            nxt_phase;
	logic [INSTR_W-1:0]    ir_ff;      // instruction being executed
	logic [INSTR_W-1:0]    nxt_ir;

	// architectural state
	logic [DATA_W-1:0]     w_ff;       // accumulator
	logic [DATA_W-1:0]     nxt_w;
	logic [DATA_W-1:0]     status_ff;  // carry, digit carry, zero
	logic [DATA_W-1:0]     nxt_status;
	logic [PC_W-1:0]       pc_ff;      // program counter
	logic [PC_W-1:0]       nxt_pc;
	logic                  skip_ff;    // next instruction is squashed
	logic                  nxt_skip;
	logic [PORT_W-1:0]     lat_ff;     // port output data latch
	logic [PORT_W-1:0]     nxt_lat;
	logic [PORT_W-1:0]     oe_ff;      // driver enable, inverse of direction
	logic [PORT_W-1:0]     nxt_oe;
	logic [DATA_W-1:0]     timer_ff;   // timer count file
	logic [DATA_W-1:0]     nxt_timer;
	logic [DATA_W-1:0]     presc_ff;   // timer prescaler
	logic [DATA_W-1:0]     nxt_presc;
	logic [DATA_W-1:0]     ctrl_ff;    // software control bits
	logic [DATA_W-1:0]     nxt_ctrl;
	logic [1:0]            cyc_ff;     // free running cycle divider
	logic [1:0]            nxt_cyc;
	logic [DATA_W-1:0]     ram_ff  [FILES];  // general purpose files
	logic [DATA_W-1:0]     nxt_ram [FILES];

	// register port read data
	logic [BUS_W-1:0]      rdata_ff;
	logic [BUS_W-1:0]      nxt_rdata;

	// decode and write port
	bbie_op_t              op;         // decoded operation
	logic [FILE_AW-1:0]    fidx;       // file address field
	logic                  dsel;       // destination select bit
	logic [DATA_W-1:0]     fval;       // file operand as read
	logic                  commit;     // last period of execute cycle
	logic                  exec;       // commit of a non-squashed op
	logic                  to_file;    // result goes to a file
	logic                  to_w;       // result goes to accumulator
	logic                  pc_chg;     // op changes the program counter
	logic                  fw_en;      // shared file write strobe
	logic [FILE_AW-1:0]    fw_idx;     // shared file write index
	logic [DATA_W-1:0]     fw_val;     // shared file write data
	logic                  bus_file;   // port access hits a file
	logic                  idle;       // no instruction in flight

	bbie_alu_if alu_bus ();

	bbie_alu u_alu (
		.io (alu_bus)
	);

	// reading a file; the port file returns the pins
	function automatic logic [DATA_W-1:0] rd_file(input logic [FILE_AW-1:0] idx);
		logic [DATA_W-1:0] v;
		v = ram_ff[idx];
		case (idx)
			F_TIMER:  v = timer_ff;
			F_PCL:    v = pc_ff[DATA_W-1:0];
			F_STATUS: v = status_ff;
			F_PORT:   v = gp_pin_in;
			default:  v = ram_ff[idx];
		endcase
		return v;
	endfunction

	// instruction decode
	always_comb begin
		fidx = ir_ff[F_HI:F_LO];
		dsel = ir_ff[D_POS];
		op   = op_nop;
		if (ir_ff[OPC6_HI:OPC6_LO] == OPC6_ADD) begin
			op = op_add;
		end else if (ir_ff[OPC6_HI:OPC6_LO] == OPC6_AND) begin
			op = op_and;
		end else if (ir_ff[OPC6_HI:OPC6_LO] == OPC6_MOVE) begin
			op = op_move;
		end else if (ir_ff[OPC4_HI:OPC4_LO] == OPC4_BCLR) begin
			op = op_bclr;
		end else if (ir_ff[OPC4_HI:OPC4_LO] == OPC4_BSET) begin
			op = op_bset;
		end else if (ir_ff[OPC4_HI:OPC4_LO] == OPC4_SKC) begin
			op = op_skc;
		end else if (ir_ff[OPC4_HI:OPC4_LO] == OPC4_SKS) begin
			op = op_sks;
		end else if (ir_ff[OPC4_HI:OPC4_LO] == OPC4_LAND) begin
			op = op_land;
		end else if (ir_ff[OPC3_HI:OPC3_LO] == OPC3_BRANCH) begin
			op = op_branch;
		end else if (ir_ff == DIRLD_WORD) begin
			op = op_dirld;
		end
	end

	// operands and destination routing
	always_comb begin
		fval          = rd_file(fidx);
		alu_bus.op    = op;
		alu_bus.acc   = w_ff;
		alu_bus.bsel  = ir_ff[B_HI:B_LO];
		alu_bus.opnd  = (op == op_land) ? ir_ff[K_HI:K_LO] : fval;
		idle          = (state_ff == st_idle);
		commit        = (state_ff == st_run) && (phase_ff == PHASE_LAST);
		// a squashed slot still spends its cycle and steps the counter, but writes nothing
		exec          = commit && !skip_ff;
		to_file       = ((op == op_add || op == op_and || op == op_move) && dsel)
			|| op == op_bclr || op == op_bset;
		to_w          = ((op == op_add || op == op_and || op == op_move) && !dsel)
			|| op == op_land;
		pc_chg        = exec && (op == op_branch || (to_file && fidx == F_PCL));
		bus_file      = (bus_addr & FILE_MASK) == FILE_BASE;
		// bus file writes only land while idle, so never clash with exec
		fw_en         = (exec && to_file) || (bus_wr && bus_file && idle);
		fw_idx        = exec ? fidx : bus_addr[FIDX_HI:FIDX_LO];
		fw_val        = exec ? alu_bus.res : bus_wdata[DATA_W-1:0];
	end

	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff + 2'h1;
		nxt_ir    = ir_ff;
		case (state_ff)
			st_idle: begin
				nxt_phase = PHASE_FIRST;
				// writes to the instruction word while busy are dropped
				if (bus_wr && bus_addr == REG_INSTR) begin
					nxt_ir    = bus_wdata[INSTR_W-1:0];
					nxt_state = st_run;
				end
			end
			st_run: begin
				if (phase_ff == PHASE_LAST) begin
					nxt_state = pc_chg ? st_stall : st_idle;
				end
			end
			st_stall: begin
				if (phase_ff == PHASE_LAST) begin
					nxt_state = st_idle;
				end
			end
			default: begin
				nxt_state = st_idle;
				nxt_phase = PHASE_FIRST;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_ff <= st_idle;
			phase_ff <= PHASE_FIRST;
			ir_ff    <= '0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			ir_ff    <= nxt_ir;
		end
	end

	// datapath next state
	always_comb begin
		nxt_w      = w_ff;
		nxt_status = status_ff;
		nxt_pc     = pc_ff;
		nxt_skip   = skip_ff;
		nxt_lat    = lat_ff;
		nxt_oe     = oe_ff;
		nxt_timer  = timer_ff;
		nxt_presc  = presc_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_cyc    = cyc_ff + 2'h1;
		nxt_ram    = ram_ff;
		// timer advances once per instruction cycle, optionally prescaled
		if (cyc_ff == PHASE_LAST) begin
			if (ctrl_ff[CTRL_ASSIGN]) begin
				nxt_presc = presc_ff + 8'h01;
				if (presc_ff == PRESC_MAX) begin
					nxt_timer = timer_ff + 8'h01;
				end
			end else begin
				nxt_timer = timer_ff + 8'h01;
			end
		end
		// every executed slot, squashed or not, steps the counter
		if (commit) begin
			nxt_pc   = pc_ff + PC_STEP;
			nxt_skip = exec && alu_bus.skip_hit;
		end
		if (exec && op == op_branch) begin
			nxt_pc = ir_ff[PC_W-1:0]; // full target, bit nine kept
		end
		if (exec && op == op_dirld) begin
			nxt_oe = ~w_ff;
		end
		if (exec && to_w) begin
			nxt_w = alu_bus.res;
		end
		// file writes, from an instruction or from the port
		if (fw_en) begin
			case (fw_idx)
				F_TIMER: begin
					nxt_timer = fw_val;
					if (ctrl_ff[CTRL_ASSIGN]) begin
						nxt_presc = RST_BYTE;
					end
				end
				F_PCL:    nxt_pc = {1'b0, fw_val};
				F_STATUS: nxt_status = fw_val;
				F_PORT:   nxt_lat = fw_val;
				default:  nxt_ram[fw_idx] = fw_val;
			endcase
		end
		// flag updates land after any write to the status file
		if (exec && alu_bus.upd_cdc) begin
			nxt_status[ST_C]  = alu_bus.c;
			nxt_status[ST_DC] = alu_bus.dc;
		end
		if (exec && alu_bus.upd_z) begin
			nxt_status[ST_Z] = alu_bus.z;
		end
		// accumulator and control from the port, idle only for w
		if (bus_wr && bus_addr == REG_W && idle) begin
			nxt_w = bus_wdata[DATA_W-1:0];
		end
		if (bus_wr && bus_addr == REG_CTRL) begin
			nxt_ctrl = bus_wdata[DATA_W-1:0];
		end
	end

	// datapath registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			w_ff      <= RST_BYTE;
			status_ff <= RST_BYTE;
			pc_ff     <= RST_PC;
			skip_ff   <= 1'b0;
			lat_ff    <= RST_BYTE;
			oe_ff     <= RST_OE;
			timer_ff  <= RST_BYTE;
			presc_ff  <= RST_BYTE;
			ctrl_ff   <= RST_BYTE;
			cyc_ff    <= PHASE_FIRST;
			for (int i = 0; i < FILES; i++) begin
				ram_ff[i] <= RST_BYTE;
			end
		end else begin
			w_ff      <= nxt_w;
			status_ff <= nxt_status;
			pc_ff     <= nxt_pc;
			skip_ff   <= nxt_skip;
			lat_ff    <= nxt_lat;
			oe_ff     <= nxt_oe;
			timer_ff  <= nxt_timer;
			presc_ff  <= nxt_presc;
			ctrl_ff   <= nxt_ctrl;
			cyc_ff    <= nxt_cyc;
			ram_ff    <= nxt_ram;
		end
	end

	// register port read mux; data only in the cycle after the strobe
	always_comb begin
		nxt_rdata = '0;
		if (bus_rd) begin
			if (bus_file) begin
				nxt_rdata[DATA_W-1:0] = rd_file(bus_addr[FIDX_HI:FIDX_LO]);
			end else begin
				case (bus_addr)
					REG_INSTR:  nxt_rdata[INSTR_W-1:0] = ir_ff;
					REG_W:      nxt_rdata[DATA_W-1:0] = w_ff;
					REG_STATUS: nxt_rdata[DATA_W-1:0] = status_ff;
					REG_PC:     nxt_rdata[PC_W-1:0] = pc_ff;
					REG_DIR:    nxt_rdata[PORT_W-1:0] = ~oe_ff;
					REG_CTRL:   nxt_rdata[DATA_W-1:0] = ctrl_ff;
					REG_PRESC:  nxt_rdata[DATA_W-1:0] = presc_ff;
					REG_STATE: begin
						nxt_rdata[STATE_BUSY] = !idle;
						nxt_rdata[STATE_SKIP] = skip_ff;
					end
					default:    nxt_rdata = '0;
				endcase
			end
		end
	end

	// read data register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// outputs straight from flops; oe high means the pin is driven
	assign bus_rdata  = rdata_ff;
	assign gp_pin_out = lat_ff;
	assign gp_pin_oe  = oe_ff;

endmodule

//--- verilog/bbie_pkg.sv
package bbie_pkg;

	// datapath and bus widths
	localparam int DATA_W   = 8;
	localparam int INSTR_W  = 12;
	localparam int PC_W     = 9;
	localparam int FILE_AW  = 5;
	localparam int FILES    = 32;
	localparam int BIT_AW   = 3;
	localparam int ADDR_W   = 8;
	localparam int BUS_W    = 32;

	// four oscillator periods make one instruction cycle
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_FIRST = 2'h0;

	// register port byte addresses
	localparam logic [ADDR_W-1:0] REG_INSTR  = 8'h00;
	localparam logic [ADDR_W-1:0] REG_W      = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_PC     = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_DIR    = 8'h10;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PRESC  = 8'h18;
	localparam logic [ADDR_W-1:0] REG_STATE  = 8'h1C;
	localparam logic [ADDR_W-1:0] FILE_BASE  = 8'h80;
	localparam logic [ADDR_W-1:0] FILE_MASK  = 8'h83;
	localparam int FIDX_HI = 6;
	localparam int FIDX_LO = 2;

	// special file indices
	localparam logic [FILE_AW-1:0] F_TIMER  = 5'h01;
	localparam logic [FILE_AW-1:0] F_PCL    = 5'h02;
	localparam logic [FILE_AW-1:0] F_STATUS = 5'h03;
	localparam logic [FILE_AW-1:0] F_PORT   = 5'h06;

	// status, control and state bit positions
	localparam int ST_C   = 0;
	localparam int ST_DC  = 1;
	localparam int ST_Z   = 2;
	localparam int CTRL_ASSIGN = 0;
	localparam int STATE_BUSY  = 0;
	localparam int STATE_SKIP  = 1;

	// instruction field positions
	localparam int OPC6_HI = 11;
	localparam int OPC6_LO = 6;
	localparam int OPC4_HI = 11;
	localparam int OPC4_LO = 8;
	localparam int OPC3_HI = 11;
	localparam int OPC3_LO = 9;
	localparam int D_POS   = 5;
	localparam int B_HI    = 7;
	localparam int B_LO    = 5;
	localparam int F_HI    = 4;
	localparam int F_LO    = 0;
	localparam int K_HI    = 7;
	localparam int K_LO    = 0;

	// opcode encodings
	localparam logic [5:0] OPC6_ADD   = 6'h07;
	localparam logic [5:0] OPC6_AND   = 6'h05;
	localparam logic [5:0] OPC6_MOVE  = 6'h08;
	localparam logic [3:0] OPC4_BCLR  = 4'h4;
	localparam logic [3:0] OPC4_BSET  = 4'h5;
	localparam logic [3:0] OPC4_SKC   = 4'h6;
	localparam logic [3:0] OPC4_SKS   = 4'h7;
	localparam logic [3:0] OPC4_LAND  = 4'hE;
	localparam logic [2:0] OPC3_BRANCH = 3'h5;
	localparam logic [INSTR_W-1:0] DIRLD_WORD = 12'h006;

	// reset values, prescaler limit and counter step
	localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
	localparam logic [DATA_W-1:0] RST_OE    = 8'h00;
	localparam logic [DATA_W-1:0] PRESC_MAX = 8'hFF;
	localparam logic [PC_W-1:0]   RST_PC    = 9'h000;
	localparam logic [PC_W-1:0]   PC_STEP   = 9'h001;

	typedef enum logic [3:0] {
		op_nop, op_add, op_and, op_move, op_land, op_bclr,
		op_bset, op_skc, op_sks, op_dirld, op_branch
	} bbie_op_t;

	typedef enum logic [2:0] {
		st_idle  = 3'b001,
		st_run   = 3'b010,
		st_stall = 3'b100
	} bbie_state_t;

endpackage

//--- verilog/bbie_alu_if.sv
`timescale 1ns/1ps
interface bbie_alu_if;
	import bbie_pkg::*;
	bbie_op_t                op;       // decoded operation
	logic [DATA_W-1:0]       acc;      // accumulator operand
	logic [DATA_W-1:0]       opnd;     // file or literal operand
	logic [BIT_AW-1:0]       bsel;     // bit number
	logic [DATA_W-1:0]       res;      // result byte
	logic                    c;        // carry out
	logic                    dc;       // digit carry out
	logic                    z;        // result is zero
	logic                    upd_cdc;  // op writes carry and digit carry
	logic                    upd_z;    // op writes zero flag
	logic                    skip_hit; // bit test succeeded
	modport calc (input op, acc, opnd, bsel,
		output res, c, dc, z, upd_cdc, upd_z, skip_hit);
	modport core (output op, acc, opnd, bsel,
		input res, c, dc, z, upd_cdc, upd_z, skip_hit);
endinterface

//--- verilog/bbie_alu.sv
`timescale 1ns/1ps
module bbie_alu
	import bbie_pkg::*;
(
	bbie_alu_if.calc io
);

	logic [DATA_W:0]   sum;    // nine-bit sum for carry
	logic [4:0]        nib;    // low nibble sum for digit carry

	// pure combinational result and flag logic
	always_comb begin
		sum         = {1'b0, io.acc} + {1'b0, io.opnd};
		nib         = {1'b0, io.acc[3:0]} + {1'b0, io.opnd[3:0]};
		io.res      = io.opnd;
		io.c        = sum[DATA_W];
		io.dc       = nib[4];
		io.upd_cdc  = 1'b0;
		io.upd_z    = 1'b0;
		io.skip_hit = 1'b0;
		case (io.op)
			op_add: begin
				io.res     = sum[DATA_W-1:0];
				io.upd_cdc = 1'b1;
				io.upd_z   = 1'b1;
			end
			op_and, op_land: begin
				io.res   = io.acc & io.opnd;
				io.upd_z = 1'b1;
			end
			op_move: begin
				io.upd_z = 1'b1;
			end
			op_bclr: io.res[io.bsel] = 1'b0;
			op_bset: io.res[io.bsel] = 1'b1;
			op_skc:  io.skip_hit = ~io.opnd[io.bsel];
			op_sks:  io.skip_hit = io.opnd[io.bsel];
			default: io.res = io.opnd;
		endcase
		// zero flag follows the byte actually produced
		io.z = (io.res == RST_BYTE);
	end

endmodule

//--- test/bbie_core_props.sv
`timescale 1ns/1ps
module bbie_core_props
	import bbie_pkg::*;
#(
	parameter int PORT_W = DATA_W
)(
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [BUS_W-1:0]  bus_wdata,
	input wire logic              bus_wr,
	input wire logic              bus_rd,
	input wire logic [BUS_W-1:0]  bus_rdata,
	input wire logic [PORT_W-1:0] gp_pin_in,
	input wire logic [PORT_W-1:0] gp_pin_out,
	input wire logic [PORT_W-1:0] gp_pin_oe
);
	// file slots as seen on the bus
	localparam logic [ADDR_W-1:0] A_TMR  = FILE_BASE + 8'h04;
	localparam logic [ADDR_W-1:0] A_PCL  = FILE_BASE + 8'h08;
	localparam logic [ADDR_W-1:0] A_PORT = FILE_BASE + 8'h18;
	logic ctrl_ff;  // shadow of prescaler assignment
	logic nxt_ctrl; // next shadow value
	logic ins_wr;   // instruction handed over
	logic dir_wr;   // direction load handed over
	assign ins_wr = bus_wr && bus_addr == REG_INSTR;
	assign dir_wr = ins_wr && bus_wdata[INSTR_W-1:0] == DIRLD_WORD;
	// control writes are never refused, so the shadow stays exact
	always_comb nxt_ctrl = (bus_wr && bus_addr == REG_CTRL) ? bus_wdata[CTRL_ASSIGN] : ctrl_ff;
	// shadow register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) ctrl_ff <= 1'b0;
		else ctrl_ff <= nxt_ctrl;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == '0)
		else $error("read data not zero outside read slot");
	a_pins_read: assert property (
		bus_rd && bus_addr == A_PORT |=> bus_rdata[PORT_W-1:0] == $past(gp_pin_in))
		else $error("port read does not show pin levels");
	a_dir_mirror: assert property (
		bus_rd && bus_addr == REG_DIR |=> bus_rdata[PORT_W-1:0] == ~$past(gp_pin_oe))
		else $error("direction read is not inverse of enables");
	a_oe_cause: assert property (
		$changed(gp_pin_oe) |-> $past(dir_wr, 4) || $past(dir_wr, 5))
		else $error("driver enables changed without direction load");
	a_out_cause: assert property (
		$changed(gp_pin_out) |->
		$past(ins_wr, 4) || $past(ins_wr, 5) || $past(bus_wr && bus_addr == A_PORT))
		else $error("port latch changed off the commit slot");
	a_pc_bit8: assert property (
		bus_wr && bus_addr == A_PCL ##[1:3] bus_rd && bus_addr == REG_PC |=> !bus_rdata[8])
		else $error("pc bit eight kept after low byte write");
	a_presc_clear: assert property (
		ctrl_ff && bus_wr && bus_addr == A_TMR ##[1:3] bus_rd && bus_addr == REG_PRESC
		|=> bus_rdata <= 32'h00000001)
		else $error("prescaler not cleared by timer write");
	a_status_width: assert property (
		bus_rd && bus_addr == REG_STATUS |=> bus_rdata[BUS_W-1:3] == '0)
		else $error("status carries bits beyond the flags");
	c_dir_load: cover property (dir_wr);
	c_pcl_write: cover property (bus_wr && bus_addr == A_PCL);
	c_presc_clear: cover property (ctrl_ff && bus_wr && bus_addr == A_TMR);
endmodule
bind bbie_core bbie_core_props #(.PORT_W(PORT_W)) u_props (
	.core_clk  (core_clk),
	.reset     (reset),
	.bus_addr  (bus_addr),
	.bus_wdata (bus_wdata),
	.bus_wr    (bus_wr),
	.bus_rd    (bus_rd),
	.bus_rdata (bus_rdata),
	.gp_pin_in (gp_pin_in),
	.gp_pin_out(gp_pin_out),
	.gp_pin_oe (gp_pin_oe)
);

//--- test/bbie_core_test.sv
`timescale 1ns/1ps
module bbie_core_test;
	import bbie_pkg::*;
	logic              core_clk;
	logic              reset;
	logic [ADDR_W-1:0] bus_addr;
	logic [BUS_W-1:0]  bus_wdata;
	logic              bus_wr;
	logic              bus_rd;
	logic [BUS_W-1:0]  bus_rdata;
	logic [7:0]        gp_pin_in;
	logic [7:0]        gp_pin_out;
	logic [7:0]        gp_pin_oe;
	logic [BUS_W-1:0]  rv;       // last read word
	int                error_cnt;
	int                num_checks;
	int                m_w, m_st, m_pc, m_oe, m_skip; // reference state
	int                m_f[32];  // reference files, slot 6 is the latch
	int                base_n;   // polls of a one-cycle instruction, idle seen at the third

	bbie_core DUT (
		.core_clk  (core_clk),
		.reset     (reset),
		.bus_addr  (bus_addr),
		.bus_wdata (bus_wdata),
		.bus_wr    (bus_wr),
		.bus_rd    (bus_rd),
		.bus_rdata (bus_rdata),
		.gp_pin_in (gp_pin_in),
		.gp_pin_out(gp_pin_out),
		.gp_pin_oe (gp_pin_oe)
	);

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// watchdog: the tests need about four thousand cycles, this allows five times that
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// one-cycle strobes, driven just after the edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		@(posedge core_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] v);
		@(posedge core_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 v = bus_rdata;
	endtask

	// reference step of one instruction
	task automatic model(input logic [INSTR_W-1:0] ins, output int lng);
		int f, b, v, r, wb;
		f = ins[F_HI:F_LO];
		b = ins[B_HI:B_LO];
		v = (f == 6) ? gp_pin_in : (f == 2) ? m_pc % 256 : m_f[f];
		wb = 0;
		lng = 0;
		m_pc = m_pc + 1;
		if (m_skip) m_skip = 0;
		else if (ins[OPC3_HI:OPC3_LO] == OPC3_BRANCH) begin
			m_pc = ins[8:0];
			lng = 1;
		end else if (ins[OPC6_HI:OPC6_LO] == OPC6_ADD) begin
			r = m_w + v;
			m_st = (m_st & 4) | (r > 255) | ((m_w % 16 + v % 16 > 15) << 1);
			wb = ins[D_POS] + 1;
		end else if (ins[OPC6_HI:OPC6_LO] == OPC6_AND) begin
			r = m_w & v;
			wb = ins[D_POS] + 1;
		end else if (ins[OPC6_HI:OPC6_LO] == OPC6_MOVE) begin
			r = v;
			wb = ins[D_POS] + 1;
		end else if (ins[OPC4_HI:OPC4_LO] == OPC4_LAND) begin
			r = m_w & ins[K_HI:K_LO];
			wb = 1;
		end
		else if (ins[OPC4_HI:OPC4_LO] == OPC4_BCLR) m_f[f] = v & ~(1 << b);
		else if (ins[OPC4_HI:OPC4_LO] == OPC4_BSET) m_f[f] = v | (1 << b);
		else if (ins[OPC4_HI:OPC4_LO] == OPC4_SKC) m_skip = ((v >> b) & 1) == 0;
		else if (ins[OPC4_HI:OPC4_LO] == OPC4_SKS) m_skip = ((v >> b) & 1) == 1;
		else if (ins == DIRLD_WORD) m_oe = ~m_w & 255;
		if (wb == 2) m_f[f] = r % 256;
		else if (wb == 1) m_w = r % 256;
		if (wb > 0) m_st = (m_st & 3) | ((r % 256 == 0) << 2);
		if (wb == 2 && f == 2) begin
			m_pc = m_f[2];
			lng = 1;
		end
		m_pc = m_pc % 512;
	endtask

	// hand over, wait for idle, compare poll count and skip flag
	task automatic exec(input logic [INSTR_W-1:0] ins);
		int n;
		int lng;
		wr(REG_INSTR, {20'h00000, ins});
		for (n = 0; n < 12; n++) begin
			rd(REG_STATE, rv);
			if (rv[STATE_BUSY] === 1'b0) break;
		end
		model(ins, lng);
		chk("exec_len", n, base_n + 2 * lng);
		chk("skip", rv[STATE_SKIP], m_skip);
	endtask

	task automatic verify(input int f);
		rd(REG_W, rv);
		chk("w", rv, m_w);
		rd(REG_STATUS, rv);
		chk("status", rv, m_st);
		rd(REG_PC, rv);
		chk("pc", rv, m_pc);
		rd(REG_DIR, rv);
		chk("dir", rv, ~m_oe & 255);
		chk("oe", gp_pin_oe, m_oe);
		chk("out", gp_pin_out, m_f[6]);
		if (f != 6) begin
			rd(FILE_BASE + ADDR_W'(f * 4), rv);
			chk("file", rv, m_f[f]);
		end
	endtask

	task automatic t_directed();
		exec(12'h000);
		exec({OPC3_BRANCH, 9'h1F0});
		exec({OPC6_AND, 1'b1, F_PCL});
		verify(0);
		exec({OPC3_BRANCH, 9'h155});
		wr(FILE_BASE + 8'h08, 32'h0000005A);
		m_pc = 90;
		rd(REG_PC, rv);
		chk("pc_bus", rv, m_pc);
		wr(FILE_BASE + 8'h18, 32'h000000FF);
		m_f[6] = 255;
		@(posedge core_clk);
		gp_pin_in <= 8'h0F;
		exec({OPC6_MOVE, 1'b1, F_PORT});
		wr(REG_W, 32'h000000A5);
		m_w = 165;
		exec(DIRLD_WORD);
		verify(6);
		// the port file reads back the pins; after the move the latch holds 0F as well
		rd(FILE_BASE + 8'h18, rv);
		chk("pins", rv, gp_pin_in);
		$display("test directed done");
	endtask

	task automatic t_timer();
		int p;
		wr(REG_CTRL, 32'h00000001);
		repeat (40) @(posedge core_clk);
		wr(FILE_BASE + 8'h04, 32'h00000000);
		rd(REG_PRESC, rv);
		chk("presc_bus", rv <= 1, 1'b1);
		exec({OPC4_BSET, 3'h0, F_TIMER});
		rd(REG_PRESC, rv);
		// three edges since the commit allow one step; without the clear it would be two or more
		chk("presc_op", rv <= 1, 1'b1);
		rd(8'h40, rv);
		chk("unmapped", rv, 0);
		wr(REG_CTRL, 32'h00000000);
		// unassigned prescaler stands still and a timer write leaves it alone
		rd(REG_PRESC, rv);
		p = rv;
		wr(FILE_BASE + 8'h04, 32'h00000055);
		rd(REG_PRESC, rv);
		chk("presc_kept", rv, p);
		$display("test timer done");
	endtask

	task automatic t_random();
		int i, f, sel;
		logic [INSTR_W-1:0] ins;
		for (i = 0; i < 32; i++) begin
			m_f[i] = $urandom % 256;
			if (!(i inside {1, 2, 3})) wr(FILE_BASE + ADDR_W'(i * 4), m_f[i]);
		end
		m_w = $urandom % 256;
		wr(REG_W, m_w);
		for (i = 0; i < 200; i++) begin
			@(posedge core_clk);
			gp_pin_in <= 8'($urandom);
			sel = $urandom % 11;
			f = $urandom % 32;
			if (f inside {1, 2, 3}) f = 6;
			ins = INSTR_W'($urandom);
			ins[F_HI:F_LO] = FILE_AW'(f);
			case (sel)
				0: ins[OPC6_HI:OPC6_LO] = OPC6_ADD;
				1: ins[OPC6_HI:OPC6_LO] = OPC6_AND;
				2: ins[OPC6_HI:OPC6_LO] = OPC6_MOVE;
				3: ins[OPC4_HI:OPC4_LO] = OPC4_LAND;
				4, 5, 6, 7: ins[OPC4_HI:OPC4_LO] = OPC4_BCLR + 4'(sel - 4);
				8: ins = DIRLD_WORD;
				9: ins[OPC3_HI:OPC3_LO] = OPC3_BRANCH;
				default: ins = {8'h00, 4'(sel)}; // other low words do nothing
			endcase
			exec(ins);
			verify(f);
		end
		$display("test random done");
	endtask

	initial begin
		reset = 1'b1;
		bus_addr = 8'h00;
		bus_wdata = 32'h00000000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		gp_pin_in = 8'h00;
		error_cnt = 0;
		num_checks = 0;
		base_n = 2;
		rv = $urandom(38020);
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		t_directed();
		t_timer();
		t_random();
		conclude();
	end
endmodule
